// ---- logic/universal_serial_unit.sv ----
// universal serial unit: shift register, 4-bit counter, clock hold
// assumes an avalon-mm master on clk_sys_in, scl/sda from outside
//
// What this block does
// - two-wire uses scl sda, no filtering
// - master clocks, slave holds, both shift
// - data output changes on falling edge
// - master checks scl really rose
// - counter advances with serial clock
// - sda fall with scl high sets flag
// - sda low on bit7 or port zero
// - start holds scl after falling edge
// - sample sda on rising scl edge
// - overflow after eight bits holds scl
// - ack by presetting counter to fourteen
// - direction one means slave drives data
// - bytes continue until stop or restart
// - sda delayed before start comparison
// - start detector only in two-wire mode
// - start detector independent of bus activity
// - serial clock at most quarter system
// - hold scl until slave ready
// - external clock counts both edges
// - counter chains with timer zero
// - preset fifteen gives edge interrupt
// - three-wire slave with external clock
// - overflow sets at wrap, write-one clears
// - start flag write-one clears, releases hold
//
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
module universal_serial_unit
  import serial_unit_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        timer_tick_in,
  output logic             timer_carry_out,
  serial_link_if.device    link
);

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    logic [1:0]              scl_sync;
    logic [1:0]              sda_sync;
    logic                    scl_prev;
    logic [sda_delay_cyc-1:0] sda_dly;
    logic [7:0]              ctrl;
    logic [7:0]              shift;
    logic [3:0]              count;
    logic                    out_latch;
    logic                    start_flag;
    logic                    ovf_flag;
    logic                    stop_flag;
    logic                    start_hold;
    logic                    start_seen;
    logic [7:0]              timer;
    logic                    carry;
    logic [31:0]             rdata;
    logic                    ack;
  } state_s;

  state_s r;
  state_s n;

  // decode of the mode field, used in several places
  function automatic logic is_mode(input logic [7:0] c,
                                   input logic [1:0] m);
    is_mode = (c[wire_mode_lsb +: 2] == m);
  endfunction : is_mode

  logic       scl_s;
  logic       sda_s;
  logic       sda_late;
  logic       scl_rise;
  logic       scl_fall;
  logic       two_wire;
  logic       ext_src;
  logic       shift_tick;
  logic       count_tick;
  logic       wr_hit;
  logic [1:0] src;

  assign scl_s    = r.scl_sync[1];
  assign sda_s    = r.sda_sync[1];
  assign sda_late = r.sda_dly[sda_delay_cyc-1];
  assign scl_rise = scl_s & ~r.scl_prev;
  assign scl_fall = ~scl_s & r.scl_prev;
  assign two_wire = is_mode(r.ctrl, mode_two);
  assign src      = r.ctrl[clk_src_lsb +: 2];
  assign ext_src  = src[1];
  // writes land only at the edge where waitrequest is seen low
  assign wr_hit   = avs_write & r.ack;

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    n = r;
    // two flops on each pin before use
    n.scl_sync = {r.scl_sync[0], link.scl};
    n.sda_sync = {r.sda_sync[0], link.sda};
    n.scl_prev = scl_s;
    n.sda_dly  = {r.sda_dly[sda_delay_cyc-2:0], sda_s};

    // timer_zero: free counter on its tick; carry feeds the unit
    n.carry = 1'b0;
    if (timer_tick_in) begin
      n.timer = r.timer + 8'h01;
      n.carry = (r.timer == 8'hff);
    end

    shift_tick = 1'b0;
    count_tick = 1'b0;
    case (src)
      src_ext_p: begin
        shift_tick = scl_rise;
        count_tick = scl_rise | scl_fall;
      end
      src_ext_n: begin
        shift_tick = scl_fall;
        count_tick = scl_rise | scl_fall;
      end
      src_timer: begin
        shift_tick = r.carry;
        count_tick = r.carry;
      end
      default: begin
        shift_tick = wr_hit && avs_address == ctrl_offset
                     && avs_writedata[sw_strobe_bit];
        count_tick = shift_tick;
      end
    endcase

    // output latch follows msb always with internal sources, only outside the sampling half with external
    if (!ext_src || (src == src_ext_p ? !scl_s : scl_s))
      n.out_latch = r.shift[7];

    if (shift_tick)
      n.shift = {r.shift[6:0], sda_s};
    if (count_tick) begin
      n.count = r.count + 4'h1;
      // overflow on wrap, preset f fires on one edge
      if (r.count == 4'hf)
        n.ovf_flag = 1'b1;
    end
    // off and three-wire modes mirror counts into flag
    if (count_tick && (is_mode(r.ctrl, mode_off)
                       || is_mode(r.ctrl, mode_three)))
      n.start_flag = 1'b1;

    // start detection only in two-wire mode
    // delayed sda high, now low, scl high
    // no dependence on serial clock source
    if (two_wire && sda_late && !sda_s && scl_s) begin
      n.start_flag = 1'b1;
      n.start_seen = 1'b1;
    end
    // hold begins at the next falling scl
    if (two_wire && r.start_seen && scl_fall) begin
      n.start_hold = 1'b1;
      n.start_seen = 1'b0;
    end
    // stop, sda rises while scl high
    if (two_wire && !sda_late && sda_s && scl_s) begin
      n.stop_flag  = 1'b1;
      n.start_seen = 1'b0;
    end

    // register writes; a write to data wins over a shift
    if (wr_hit) begin
      case (avs_address)
        ctrl_offset: n.ctrl = {1'b0, avs_writedata[6:0]};
        status_offset: begin
          // write one clears start and releases hold
          // the set above still wins in the same cycle
          if (avs_writedata[start_flag_bit] && !n.start_seen
              && !(count_tick && (is_mode(r.ctrl, mode_off)
                                  || is_mode(r.ctrl, mode_three)))) begin
            n.start_flag = 1'b0;
            n.start_hold = 1'b0;
          end
          if (avs_writedata[ovf_flag_bit] &&
              !(count_tick && r.count == 4'hf))
            n.ovf_flag = 1'b0;
          if (avs_writedata[stop_flag_bit]
              && !(two_wire && !sda_late && sda_s && scl_s))
            n.stop_flag = 1'b0;
          // preset (14 for the ack bit)
          n.count = avs_writedata[3:0];
        end
        data_offset:  n.shift = avs_writedata[7:0];
        timer_offset: n.timer = avs_writedata[7:0];
        default: ;
      endcase
    end

    // read mux; unmapped reads return zero
    n.rdata = 32'h0;
    case (avs_address)
      ctrl_offset:   n.rdata = {24'h0, r.ctrl};
      status_offset: n.rdata = {24'h0, r.start_flag, r.ovf_flag,
                               r.stop_flag,
                               two_wire & (r.shift[7] != sda_s),
                               r.count};
      data_offset:   n.rdata = {24'h0, r.shift};
      timer_offset:  n.rdata = {24'h0, r.timer};
      default:       n.rdata = 32'h0;
    endcase
    // one wait cycle per access
    n.ack = (avs_read | avs_write) & ~r.ack;
  end

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      r          <= '0;
      r.scl_sync <= 2'h3;
      r.sda_sync <= 2'h3;
      r.scl_prev <= 1'b1;
      r.sda_dly  <= '1;
      r.ctrl     <= ctrl_reset;
      r.out_latch <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // -------------------------------------------------------------
  // pins and bus
  // -------------------------------------------------------------
  // plain open drain, no edge shaping
  // pull sda when latch or port is zero, direction set
  assign link.sda_oe_dev = ~(r.ctrl[sda_dir_bit] & ~is_mode(r.ctrl,
                             mode_off) & (~r.out_latch
                             | ~r.ctrl[port_bit]));
  assign link.scl_oe_dev = ~(two_wire & r.ctrl[scl_dir_bit]
                             & (r.start_hold | r.ovf_flag));
  assign avs_readdata    = r.rdata;
  assign avs_waitrequest = (avs_read | avs_write) & ~r.ack;
  assign timer_carry_out = r.carry;

endmodule : universal_serial_unit

// ---- logic/serial_unit_pkg.sv ----
// package for the universal serial unit and its bus master end
// assumes a 250 MHz system clock on both ends
package serial_unit_pkg;

  // -------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // -------------------------------------------------------------
  localparam logic [3:0] ctrl_offset   = 4'h0; // serial_control_register
  localparam logic [3:0] status_offset = 4'h4; // serial_status_register
  localparam logic [3:0] data_offset   = 4'h8; // shift_data_register
  localparam logic [3:0] timer_offset  = 4'hc; // timer_zero low byte

  // -------------------------------------------------------------
  // control fields
  // -------------------------------------------------------------
  localparam int wire_mode_lsb  = 4;     // two bits: 00 off, 01 3w, 10 2w
  localparam int clk_src_lsb    = 2;     // two bits, bit 3 is external
  localparam int sda_dir_bit    = 1;     // sda/do output direction
  localparam int port_bit       = 0;     // port level on the data pin
  localparam int scl_dir_bit    = 6;     // slave may pull scl
  localparam int sw_strobe_bit  = 7;     // write one: software clock

  // -------------------------------------------------------------
  // status fields
  // -------------------------------------------------------------
  localparam int start_flag_bit = 7;
  localparam int ovf_flag_bit   = 6;
  localparam int stop_flag_bit  = 5;
  localparam int collision_bit  = 4;

  // -------------------------------------------------------------
  // encodings and reset values
  // -------------------------------------------------------------
  localparam logic [1:0] mode_off   = 2'h0;
  localparam logic [1:0] mode_three = 2'h1;
  localparam logic [1:0] mode_two   = 2'h2;
  localparam logic [1:0] src_sw     = 2'h0; // software strobe
  localparam logic [1:0] src_timer  = 2'h1; // timer_zero overflow
  localparam logic [1:0] src_ext_p  = 2'h2; // external, sample rising
  localparam logic [1:0] src_ext_n  = 2'h3; // external, sample falling
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [3:0] ack_preset = 4'he;

  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int sys_period_ns   = 4;
  localparam int sda_delay_ns    = 50;  // least sda delay for start
  localparam int sda_delay_cyc   =
    (sda_delay_ns + sys_period_ns - 1) / sys_period_ns;
  localparam int master_half_ns  = 160; // half a bus clock period
  localparam int master_half_cyc = master_half_ns / sys_period_ns;

  // master command codes
  typedef enum logic [1:0] {
    cmd_start = 2'b00,
    cmd_write = 2'b01,
    cmd_read  = 2'b10,
    cmd_stop  = 2'b11
  } cmd_e;

endpackage : serial_unit_pkg

// ---- logic/serial_link_if.sv ----
// interface joining the serial unit (device) and the bus master
// open-drain wires resolved here from the two enables (low = pull low)
`timescale 1ns/1ns
interface serial_link_if;
  logic scl_oe_dev;   // low: device pulls scl low
  logic sda_oe_dev;   // low: device pulls sda low
  logic scl_oe_mst;
  logic sda_oe_mst;
  logic scl;
  logic sda;

  // wired-and with pull-up
  assign scl = scl_oe_dev & scl_oe_mst;
  assign sda = sda_oe_dev & sda_oe_mst;

  modport device (output scl_oe_dev, output sda_oe_dev,
                  input scl, input sda);
  modport master (output scl_oe_mst, output sda_oe_mst,
                  input scl, input sda);
endinterface : serial_link_if

// ---- logic/serial_bus_master.sv ----
// two-wire bus master end: makes scl from clk_sys_in by a divider
// assumes a user issuing one command at a time on cmd_valid_in
`timescale 1ns/1ns
module serial_bus_master
  import serial_unit_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       cmd_valid_in,
  input  wire logic [1:0] cmd_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       ack_in,
  output logic            cmd_ready_out,
  output logic [7:0]      rdata_out,
  output logic            nack_out,
  output logic            done_out,
  serial_link_if.master   link
);

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_low  = 3'b001,
    st_high = 3'b010,
    st_wait = 3'b011,
    st_fin  = 3'b100
  } state_e;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    state_e     st;
    cmd_e       cmd;
    logic [8:0] bits;
    logic [3:0] idx;
    logic [7:0] tmr;
    logic       scl_o;
    logic       sda_o;
    logic [7:0] rdata;
    logic       nack;
    logic       done;
  } state_s;

  state_s r;
  state_s n;

  // -------------------------------------------------------------
  // sequencing: each bit is low half then high half
  // -------------------------------------------------------------
  always_comb begin
    n = r;
    n.scl_sync = {r.scl_sync[0], link.scl};
    n.sda_sync = {r.sda_sync[0], link.sda};
    n.done = 1'b0;
    case (r.st)
      st_idle: if (cmd_valid_in) begin
        n.cmd = cmd_e'(cmd_in);
        n.tmr = 8'(master_half_cyc);
        n.idx = 4'h0;
        // read keeps sda free, ack bit from user
        n.bits = (cmd_e'(cmd_in) == cmd_read) ?
                 {8'hff, ~ack_in} : {wdata_in, 1'b1};
        n.st = st_low;
        if (cmd_e'(cmd_in) == cmd_start) begin
          n.sda_o = 1'b0; // sda falls while scl high
        end else if (cmd_e'(cmd_in) == cmd_stop) begin
          n.scl_o = 1'b0;
          n.sda_o = 1'b0;
        end
      end
      st_low: begin
        // half periods of 41 cycles keep scl slow
        n.tmr = r.tmr - 8'h01;
        if (r.tmr == 8'h0) begin
          n.tmr = 8'(master_half_cyc);
          if (r.cmd == cmd_start) begin
            n.scl_o = 1'b0;
            n.st = st_fin;
          end else if (r.cmd == cmd_stop) begin
            n.scl_o = 1'b1;
            n.st = st_fin;
          end else begin
            n.sda_o = r.bits[8];
            n.scl_o = 1'b0;
            n.st = st_wait;
          end
        end
      end
      st_wait: begin
        n.tmr = r.tmr - 8'h01;
        if (r.tmr == 8'h0) begin
          n.scl_o = 1'b1;
          n.tmr = 8'(master_half_cyc);
          n.st = st_high;
        end
      end
      st_high: begin
        if (r.scl_sync[1]) begin
          n.tmr = r.tmr - 8'h01;
          if (r.tmr == 8'h0) begin
            n.bits = {r.bits[7:0], 1'b1};
            n.idx = r.idx + 4'h1;
            if (r.idx < 4'h8)
              n.rdata = {r.rdata[6:0], r.sda_sync[1]};
            else
              n.nack = r.sda_sync[1];
            n.scl_o = 1'b0;
            n.tmr = 8'(master_half_cyc);
            n.st = (r.idx == 4'h8) ? st_fin : st_wait;
            if (r.idx != 4'h8)
              n.sda_o = r.bits[7];
          end
        end
      end
      st_fin: begin
        n.tmr = r.tmr - 8'h01;
        if (r.tmr == 8'h0) begin
          // stop: release sda while scl high
          if (r.cmd == cmd_stop)
            n.sda_o = 1'b1;
          else if (r.cmd != cmd_start)
            n.sda_o = 1'b1;
          n.done = 1'b1;
          n.st = st_idle;
        end
      end
      default: n.st = st_idle;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      r          <= '0;
      r.st       <= st_idle;
      r.cmd      <= cmd_start;
      r.scl_sync <= 2'h3;
      r.sda_sync <= 2'h3;
      r.scl_o    <= 1'b1;
      r.sda_o    <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // master drives the clock; the device can also hold scl low
  assign link.scl_oe_mst = r.scl_o;
  assign link.sda_oe_mst = r.sda_o;
  assign cmd_ready_out   = (r.st == st_idle);
  assign rdata_out       = r.rdata;
  assign nack_out        = r.nack;
  assign done_out        = r.done;

endmodule : serial_bus_master

// ---- verification/serial_link_monitor.sv ----
// checker on the open-drain wires joining the serial unit and master
// assumes instantiation beside serial_link_if in the bench top module
`timescale 1ns/1ns
module serial_link_monitor (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic scl_oe_dev,
  input wire logic sda_oe_dev,
  input wire logic scl_oe_mst,
  input wire logic sda_oe_mst,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  // ------------------------------------------------------------
  // wire shapes
  // ------------------------------------------------------------
  sequence scl_rise; !scl ##1 scl; endsequence
  sequence scl_drop; scl ##1 !scl; endsequence
  // sda falling under a steady high scl
  sequence start_seq; scl && $past(scl) && $past(sda) && !sda; endsequence

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  scl_high_min_a: assert property (scl_rise |-> scl[*2])
    else $error("scl high phase too short");
  scl_low_min_a: assert property (scl_drop |-> !scl[*2])
    else $error("scl low phase too short");
  master_high_a: assert property (scl_rise |-> scl_oe_mst[*8])
    else $error("master lowered scl right after it rose");
  master_waits_a: assert property (scl_oe_mst && !scl |=> scl_oe_mst)
    else $error("master pulled scl before it was seen high");
  dev_grab_low_a: assert property ($fell(scl_oe_dev) |-> !$past(scl))
    else $error("device pulled scl down while it was high");
  dev_hold_min_a: assert property (
    $fell(scl_oe_dev) |=> !scl_oe_dev[*3])
    else $error("device hold of scl ended at once");
  dev_sda_edge_a: assert property (
    $changed(sda_oe_dev) |-> !scl && !$past(scl))
    else $error("device changed sda while scl high");
  start_free_a: assert property (start_seq |-> scl_oe_dev[*4])
    else $error("device held scl before the falling edge");
  reset_idle_a: assert property (
    $fell(rst_in) |-> scl_oe_dev && sda_oe_dev && scl_oe_mst && sda_oe_mst)
    else $error("wires not released after reset");
  start_seen_c: cover property (start_seq);
endmodule : serial_link_monitor

// ---- verification/two_wire_serial_shift_unit_tb.sv ----
// bench joining the serial unit and the bus master over the link
// assumes the package and interface of the design are compiled first
`timescale 1ns/1ns
module two_wire_serial_shift_unit_tb import serial_unit_pkg::*;;
  logic        clk_sys_in;
  logic        rst_in;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        timer_tick_in;
  logic        timer_carry_out;
  logic        cmd_valid_in;
  logic [1:0]  cmd_in;
  logic [7:0]  wdata_in;
  logic        ack_in;
  logic        cmd_ready_out;
  logic [7:0]  rdata_out;
  logic        nack_out;
  logic        done_out;
  logic [31:0] rd;
  logic        started;
  int          bad_count;
  int          n_checks;
  int          cycles;
  int          carries;

  serial_link_if i_serial_link_if ();
  universal_serial_unit i_universal_serial_unit (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timer_tick_in(timer_tick_in), .timer_carry_out(timer_carry_out),
    .link(i_serial_link_if));
  serial_bus_master i_serial_bus_master (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .wdata_in(wdata_in),
    .ack_in(ack_in), .cmd_ready_out(cmd_ready_out),
    .rdata_out(rdata_out), .nack_out(nack_out), .done_out(done_out),
    .link(i_serial_link_if));
  serial_link_monitor i_serial_link_monitor (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .scl_oe_dev(i_serial_link_if.scl_oe_dev),
    .sda_oe_dev(i_serial_link_if.sda_oe_dev),
    .scl_oe_mst(i_serial_link_if.scl_oe_mst),
    .sda_oe_mst(i_serial_link_if.sda_oe_mst),
    .scl(i_serial_link_if.scl), .sda(i_serial_link_if.sda));

  // clock, watchdog and carry counting
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cycles++;
    if (timer_carry_out === 1'b1) carries++;
    // a hang counts as a mismatch
    if (cycles == 40000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // control byte: hold enable, mode, source, sda drive, port high
  function automatic logic [7:0] ctl(input logic h, input logic [1:0] m,
                                     input logic [1:0] s, input logic d);
    return {1'b0, h, m, s, d, 1'b1};
  endfunction : ctl

  // one avalon access, held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [3:0] a,
                    input logic [7:0] d);
    @(posedge clk_sys_in);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    do @(posedge clk_sys_in); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av

  task automatic wait_stat(input int b);
    do av(1'b0, status_offset, 8'h00); while (rd[b] !== 1'b1);
  endtask : wait_stat

  task automatic mcmd(input logic [1:0] c, input logic [7:0] d);
    @(posedge clk_sys_in);
    cmd_valid_in <= 1'b1;
    cmd_in <= c;
    wdata_in <= d;
    do @(posedge clk_sys_in); while (cmd_ready_out !== 1'b1);
    cmd_valid_in <= 1'b0;
    do @(posedge clk_sys_in); while (done_out !== 1'b1);
  endtask : mcmd

  // slave acknowledge: sda low, counter preset, wait the ack bit
  task automatic ack_byte();
    av(1'b1, data_offset, 8'h00);
    av(1'b1, ctrl_offset, ctl(1'b1, mode_two, src_ext_p, 1'b1));
    // the pin follows the write only after its edge
    @(posedge clk_sys_in);
    chk(i_serial_link_if.sda, 1'b0);
    av(1'b1, status_offset, {4'h4, ack_preset});
    wait_stat(ovf_flag_bit);
    chk(rd[3:0], 4'h0);
    av(1'b1, ctrl_offset, ctl(1'b1, mode_two, src_ext_p, 1'b0));
  endtask : ack_byte

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    av(1'b0, ctrl_offset, 8'h00);
    chk(rd, {24'h0, ctrl_reset});
    av(1'b0, status_offset, 8'h00);
    chk(rd, 32'h0);
    av(1'b1, 4'h2, 8'hff);
    av(1'b0, 4'h2, 8'h00);
    chk(rd, 32'h0);
    $display("regs test done");
  endtask : t_regs

  task automatic t_modes();
    av(1'b1, ctrl_offset, ctl(1'b0, mode_off, src_sw, 1'b0));
    av(1'b1, status_offset, 8'he0);
    mcmd(cmd_start, 8'h00);
    av(1'b0, status_offset, 8'h00);
    chk(rd[start_flag_bit], 1'b0);
    mcmd(cmd_stop, 8'h00);
    av(1'b1, ctrl_offset, ctl(1'b0, mode_off, src_ext_p, 1'b0));
    av(1'b1, status_offset, 8'hef);
    mcmd(cmd_start, 8'h00);
    av(1'b0, status_offset, 8'h00);
    chk(rd[ovf_flag_bit], 1'b1);
    mcmd(cmd_stop, 8'h00);
    av(1'b0, status_offset, 8'h00);
    chk(rd[3:0], 4'h1);
    $display("modes test done");
  endtask : t_modes

  task automatic t_write();
    started = 1'b0;
    // clear the overflow left by the mode test before holds are allowed
    av(1'b1, status_offset, 8'he0);
    av(1'b1, ctrl_offset, ctl(1'b1, mode_two, src_ext_p, 1'b0));
    fork
      begin
        mcmd(cmd_start, 8'h00);
        started = 1'b1;
        mcmd(cmd_write, 8'ha4);
      end
      begin
        wait_stat(start_flag_bit);
        av(1'b1, status_offset, 8'h00);
        av(1'b0, status_offset, 8'h00);
        chk(rd[start_flag_bit], 1'b1);
        wait (started === 1'b1);
        // master has released scl by now, so only the hold keeps it low
        repeat (2 * master_half_cyc + 8) @(posedge clk_sys_in);
        chk(i_serial_link_if.scl, 1'b0);
        av(1'b1, status_offset, 8'h80);
        wait_stat(ovf_flag_bit);
        av(1'b0, data_offset, 8'h00);
        chk(rd[7:0], 8'ha4);
        ack_byte();
        av(1'b1, status_offset, 8'h40);
      end
    join
    chk(nack_out, 1'b0);
    mcmd(cmd_stop, 8'h00);
    av(1'b0, status_offset, 8'h00);
    chk(rd[stop_flag_bit], 1'b1);
    $display("write test done");
  endtask : t_write

  task automatic t_read();
    av(1'b1, status_offset, 8'he0);
    ack_in <= 1'b0;
    fork
      begin
        mcmd(cmd_start, 8'h00);
        mcmd(cmd_write, 8'ha5);
        mcmd(cmd_read, 8'h00);
      end
      begin
        wait_stat(start_flag_bit);
        // a clear is ignored until the start hold has begun
        repeat (master_half_cyc + 8) @(posedge clk_sys_in);
        av(1'b1, status_offset, 8'h80);
        wait_stat(ovf_flag_bit);
        av(1'b0, data_offset, 8'h00);
        chk(rd[0], 1'b1);
        ack_byte();
        av(1'b1, data_offset, 8'h3c);
        av(1'b1, ctrl_offset, ctl(1'b1, mode_two, src_ext_p, 1'b1));
        av(1'b1, status_offset, 8'h40);
        wait_stat(ovf_flag_bit);
        av(1'b1, ctrl_offset, ctl(1'b1, mode_two, src_ext_p, 1'b0));
        av(1'b1, status_offset, {4'h4, ack_preset});
        wait_stat(ovf_flag_bit);
        av(1'b1, status_offset, 8'h40);
      end
    join
    chk(rdata_out, 8'h3c);
    mcmd(cmd_stop, 8'h00);
    $display("read test done");
  endtask : t_read

  task automatic t_timer();
    av(1'b1, ctrl_offset, ctl(1'b0, mode_three, src_timer, 1'b0));
    av(1'b1, status_offset, 8'he0);
    av(1'b1, timer_offset, 8'hfe);
    carries = 0;
    repeat (2) begin
      @(posedge clk_sys_in);
      timer_tick_in <= 1'b1;
      @(posedge clk_sys_in);
      timer_tick_in <= 1'b0;
    end
    av(1'b0, status_offset, 8'h00);
    chk(rd[3:0], 4'h1);
    chk(carries, 1);
    chk(rd[start_flag_bit], 1'b1);
    // software strobe: select the source first, then strobe
    av(1'b1, ctrl_offset, ctl(1'b0, mode_three, src_sw, 1'b0));
    av(1'b1, ctrl_offset, 8'h80 | ctl(1'b0, mode_three, src_sw, 1'b0));
    av(1'b0, status_offset, 8'h00);
    chk(rd[3:0], 4'h2);
    $display("timer test done");
  endtask : t_timer

  // main sequence
  initial begin
    rst_in = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    timer_tick_in = 1'b0;
    cmd_valid_in = 1'b0;
    cmd_in = 2'h0;
    wdata_in = 8'h00;
    ack_in = 1'b0;
    started = 1'b0;
    bad_count = 0;
    n_checks = 0;
    cycles = 0;
    carries = 0;
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_regs();
    t_modes();
    t_write();
    t_read();
    t_timer();
    wrap_up();
  end
endmodule : two_wire_serial_shift_unit_tb
